// ===== pkg/tv_timing_pkg.sv
// Purpose: constants and carriers for the tv standard line timing block
// Assumes: byte-wide register port on the pixel clock
// Notes:   register window covers offsets 0x0F to 0x1E
`default_nettype none
package tv_timing_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] STANDARDS_CONTROL_OFS        = 8'h0F;
  localparam logic [7:0] SYNC_TIP_LENGTH_OFS          = 8'h10;
  localparam logic [7:0] BREEZEWAY_LENGTH_OFS         = 8'h11;
  localparam logic [7:0] BURST_LENGTH_OFS             = 8'h12;
  localparam logic [7:0] COLOR_BACK_PORCH_LENGTH_OFS  = 8'h13;
  localparam logic [7:0] EXTENDED_BACK_PORCH_LOW_OFS  = 8'h14;
  localparam logic [7:0] ACTIVE_VIDEO_LOW_OFS         = 8'h15;
  localparam logic [7:0] ACTIVE_START_HALF_LOW_OFS    = 8'h16;
  localparam logic [7:0] ACTIVE_END_HALF_LOW_OFS      = 8'h17;
  localparam logic [7:0] TIMING_HIGH_BITS_OFS         = 8'h18;
  localparam logic [7:0] FRONT_PORCH_LENGTH_OFS       = 8'h19;
  localparam logic [7:0] EQUALIZATION_LOW_LENGTH_OFS  = 8'h1A;
  localparam logic [7:0] EQUALIZATION_HIGH_LENGTH_OFS = 8'h1B;
  localparam logic [7:0] VERTICAL_SYNC_LOW_LENGTH_OFS = 8'h1C;
  localparam logic [7:0] VERTICAL_SYNC_HIGH_LENGTH_OFS = 8'h1D;
  localparam logic [7:0] COLOR_BAR_WIDTH_OFS          = 8'h1E;
  localparam logic [7:0] REG_RESET                    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ                = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT   = 7;
  localparam int LINE625_BIT  = 6;
  localparam int PAL_BIT      = 5;
  localparam int PEDESTAL_BIT = 4;
  localparam int LUMA_LSB     = 2;
  localparam int CHROMA_LSB   = 0;
  localparam int XBP_HI_LSB   = 6;
  localparam int VA_HI_LSB    = 4;
  localparam int VC_HI_LSB    = 2;
  localparam int VB_HI_LSB    = 0;

  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam logic [9:0] LINES_625       = 10'h271;
  localparam logic [9:0] LINES_525       = 10'h20D;
  localparam logic [9:0] PULSE_BASE_256  = 10'h100;
  localparam logic [9:0] PULSE_BASE_512  = 10'h200;
  localparam logic [9:0] VS_FIRST_LINE   = 10'h003;
  localparam logic [9:0] EQ2_FIRST_LINE  = 10'h006;
  localparam logic [9:0] VBI_END_LINE    = 10'h009;
  localparam logic [2:0] LAST_BAR        = 3'h7;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SEG_SYNC       = 4'h0,
    SEG_BREEZE     = 4'h1,
    SEG_BURST      = 4'h2,
    SEG_BACK_PORCH = 4'h3,
    SEG_EXT_PORCH  = 4'h4,
    SEG_ACTIVE     = 4'h5,
    SEG_FRONT      = 4'h6,
    SEG_EQ_LOW     = 4'h7,
    SEG_EQ_HIGH    = 4'h8,
    SEG_VS_LOW     = 4'h9,
    SEG_VS_HIGH    = 4'hA
  } seg_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       line_625;
    logic       pal;
    logic       pedestal;
    logic [1:0] luma_gain;
    logic [1:0] chroma_gain;
  } std_ctrl_t;

  typedef struct packed {
    logic       sync_n;
    logic       burst_gate;
    logic       active;
    logic       phase_alt;
    logic       field;
    logic [2:0] bar_index;
    logic [9:0] line;
  } timing_out_t;

endpackage : tv_timing_pkg
`default_nettype wire

// ===== src/tv_standard_line_timing_regs.sv
// Purpose: standard select and line timing registers with segment sequencer
// Assumes: register port and enable inputs are on the pixel clock
// Notes:   one read cycle latency; writes take effect on the next edge
`timescale 1ns/100ps
`default_nettype none

module tv_standard_line_timing_regs (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_n_i,
  input  wire tv_timing_pkg::reg_req_t   req_i,
  input  wire logic                      standards_regs_enable_i,
  input  wire logic                      long_pulse_offset_select_i,
  output logic [7:0]                     rdata_o,
  output tv_timing_pkg::std_ctrl_t       ctrl_o,
  output tv_timing_pkg::timing_out_t     timing_o
);

  typedef struct packed {
    logic [15:0][7:0]           regs;
    tv_timing_pkg::seg_t        seg;
    logic [9:0]                 cnt;
    logic                       pulse;
    logic [7:0]                 bar_cnt;
    logic [7:0]                 rdata;
    tv_timing_pkg::std_ctrl_t   ctrl;
    tv_timing_pkg::timing_out_t tout;
  } state_t;

  state_t     st_ff;
  state_t     nxt_st;
  logic [7:0] rel_addr;
  logic [3:0] idx;
  logic       mapped;
  logic       en;
  logic [9:0] total_lines;
  logic [9:0] pulse_base;
  logic       line_end;
  logic [9:0] new_line;

  // ----------------------------------------------------------------
  // segment length lookup
  // ----------------------------------------------------------------
  function automatic logic [9:0] seg_len(input logic [15:0][7:0]   r,
                                         input tv_timing_pkg::seg_t s,
                                         input logic [9:0]          ln,
                                         input logic [9:0]          last,
                                         input logic [9:0]          base);
    logic [7:0] hi;
    hi = r[tv_timing_pkg::TIMING_HIGH_BITS_OFS[3:0] - 4'hF];
    unique case (s)
      tv_timing_pkg::SEG_SYNC:       seg_len = {2'b00, r[4'h1]};
      tv_timing_pkg::SEG_BREEZE:     seg_len = {2'b00, r[4'h2]};
      tv_timing_pkg::SEG_BURST:      seg_len = {2'b00, r[4'h3]};
      tv_timing_pkg::SEG_BACK_PORCH: seg_len = {2'b00, r[4'h4]};
      tv_timing_pkg::SEG_EXT_PORCH:
        seg_len = {hi[tv_timing_pkg::XBP_HI_LSB +: 2], r[4'h5]};
      tv_timing_pkg::SEG_ACTIVE: begin
        if (ln == tv_timing_pkg::VBI_END_LINE)
          seg_len = {hi[tv_timing_pkg::VC_HI_LSB +: 2], r[4'h7]};
        else if (ln == last)
          seg_len = {hi[tv_timing_pkg::VB_HI_LSB +: 2], r[4'h8]};
        else
          seg_len = {hi[tv_timing_pkg::VA_HI_LSB +: 2], r[4'h6]};
      end
      tv_timing_pkg::SEG_FRONT:      seg_len = {2'b00, r[4'hA]};
      tv_timing_pkg::SEG_EQ_LOW:     seg_len = {2'b00, r[4'hB]};
      tv_timing_pkg::SEG_EQ_HIGH:    seg_len = base + {2'b00, r[4'hC]};
      tv_timing_pkg::SEG_VS_LOW:     seg_len = base + {2'b00, r[4'hD]};
      tv_timing_pkg::SEG_VS_HIGH:    seg_len = {2'b00, r[4'hE]};
      default:                       seg_len = 10'h001;
    endcase
  endfunction : seg_len

  function automatic tv_timing_pkg::seg_t first_seg(input logic [9:0] ln);
    if (ln < tv_timing_pkg::VS_FIRST_LINE)
      first_seg = tv_timing_pkg::SEG_EQ_LOW;
    else if (ln < tv_timing_pkg::EQ2_FIRST_LINE)
      first_seg = tv_timing_pkg::SEG_VS_LOW;
    else if (ln < tv_timing_pkg::VBI_END_LINE)
      first_seg = tv_timing_pkg::SEG_EQ_LOW;
    else
      first_seg = tv_timing_pkg::SEG_SYNC;
  endfunction : first_seg

  // ----------------------------------------------------------------
  // decode and shared terms
  // ----------------------------------------------------------------
  assign rel_addr    = req_i.addr - tv_timing_pkg::STANDARDS_CONTROL_OFS;
  assign idx         = rel_addr[3:0];
  assign mapped      = (req_i.addr >= tv_timing_pkg::STANDARDS_CONTROL_OFS) &&
                       (req_i.addr <= tv_timing_pkg::COLOR_BAR_WIDTH_OFS);
  assign en          = standards_regs_enable_i;
  assign total_lines = st_ff.ctrl.line_625 ? tv_timing_pkg::LINES_625
                                           : tv_timing_pkg::LINES_525;
  assign pulse_base  = (en && long_pulse_offset_select_i) ?
                       tv_timing_pkg::PULSE_BASE_512 : tv_timing_pkg::PULSE_BASE_256;
  assign new_line    = (st_ff.tout.line == total_lines - 10'h001) ? 10'h000
                       : st_ff.tout.line + 10'h001;
  assign line_end    = (st_ff.cnt == 10'h000) &&
                       ((st_ff.seg == tv_timing_pkg::SEG_FRONT) ||
                        (st_ff.pulse && ((st_ff.seg == tv_timing_pkg::SEG_EQ_HIGH) ||
                                         (st_ff.seg == tv_timing_pkg::SEG_VS_HIGH))));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0]          ctl;
    logic [9:0]          len;
    logic [9:0]          ln;
    tv_timing_pkg::seg_t s;
    nxt_st = st_ff;
    ctl    = st_ff.regs[4'h0];
    len    = 10'h000;
    ln     = st_ff.tout.line;
    s      = st_ff.seg;

    // register port
    if (req_i.wr && mapped) begin
      nxt_st.regs[idx] = req_i.wdata;
    end
    if (req_i.rd) begin
      if (!mapped)
        nxt_st.rdata = tv_timing_pkg::UNMAPPED_READ;
      else if (idx == 4'h0)
        nxt_st.rdata = {en, ctl[6:0]};
      else
        nxt_st.rdata = st_ff.regs[idx];
    end

    // standard controls, forced to defaults while disabled
    nxt_st.ctrl = '0;
    if (en) begin
      nxt_st.ctrl.line_625    = ctl[tv_timing_pkg::LINE625_BIT];
      nxt_st.ctrl.pal         = ctl[tv_timing_pkg::PAL_BIT];
      nxt_st.ctrl.pedestal    = ctl[tv_timing_pkg::PEDESTAL_BIT];
      nxt_st.ctrl.luma_gain   = ctl[tv_timing_pkg::LUMA_LSB +: 2];
      nxt_st.ctrl.chroma_gain = ctl[tv_timing_pkg::CHROMA_LSB +: 2];
    end

    // segment sequencer
    if (st_ff.cnt != 10'h000) begin
      nxt_st.cnt = st_ff.cnt - 10'h001;
    end else begin
      unique case (st_ff.seg)
        tv_timing_pkg::SEG_SYNC:       s = tv_timing_pkg::SEG_BREEZE;
        tv_timing_pkg::SEG_BREEZE:     s = tv_timing_pkg::SEG_BURST;
        tv_timing_pkg::SEG_BURST:      s = tv_timing_pkg::SEG_BACK_PORCH;
        tv_timing_pkg::SEG_BACK_PORCH: s = tv_timing_pkg::SEG_EXT_PORCH;
        tv_timing_pkg::SEG_EXT_PORCH:  s = tv_timing_pkg::SEG_ACTIVE;
        tv_timing_pkg::SEG_ACTIVE:     s = tv_timing_pkg::SEG_FRONT;
        tv_timing_pkg::SEG_FRONT:      s = first_seg(new_line);
        tv_timing_pkg::SEG_EQ_LOW:     s = tv_timing_pkg::SEG_EQ_HIGH;
        tv_timing_pkg::SEG_VS_LOW:     s = tv_timing_pkg::SEG_VS_HIGH;
        tv_timing_pkg::SEG_EQ_HIGH:
          s = st_ff.pulse ? first_seg(new_line) : tv_timing_pkg::SEG_EQ_LOW;
        tv_timing_pkg::SEG_VS_HIGH:
          s = st_ff.pulse ? first_seg(new_line) : tv_timing_pkg::SEG_VS_LOW;
        default:                       s = tv_timing_pkg::SEG_SYNC;
      endcase
      if ((st_ff.seg == tv_timing_pkg::SEG_EQ_HIGH) ||
          (st_ff.seg == tv_timing_pkg::SEG_VS_HIGH))
        nxt_st.pulse = ~st_ff.pulse;
      if (line_end) begin
        ln           = new_line;
        nxt_st.pulse = 1'b0;
        if (new_line == 10'h000)
          nxt_st.tout.field = ~st_ff.tout.field;
        nxt_st.tout.phase_alt = st_ff.ctrl.pal & ~st_ff.tout.phase_alt;
      end
      len        = seg_len(st_ff.regs, s, ln, total_lines - 10'h001, pulse_base);
      nxt_st.seg = s;
      nxt_st.cnt = (len == 10'h000) ? 10'h000 : len - 10'h001;
    end
    nxt_st.tout.line = ln;

    // color bar stepping within active video
    if (nxt_st.seg == tv_timing_pkg::SEG_ACTIVE && st_ff.seg == tv_timing_pkg::SEG_ACTIVE) begin
      if (st_ff.bar_cnt + 8'h01 >= st_ff.regs[4'hF]) begin
        nxt_st.bar_cnt = 8'h00;
        if (st_ff.tout.bar_index != tv_timing_pkg::LAST_BAR)
          nxt_st.tout.bar_index = st_ff.tout.bar_index + 3'h1;
      end else begin
        nxt_st.bar_cnt = st_ff.bar_cnt + 8'h01;
      end
    end else begin
      nxt_st.bar_cnt        = 8'h00;
      nxt_st.tout.bar_index = 3'h0;
    end

    nxt_st.tout.sync_n     = ~((nxt_st.seg == tv_timing_pkg::SEG_SYNC) ||
                               (nxt_st.seg == tv_timing_pkg::SEG_EQ_LOW) ||
                               (nxt_st.seg == tv_timing_pkg::SEG_VS_LOW));
    nxt_st.tout.burst_gate = (nxt_st.seg == tv_timing_pkg::SEG_BURST);
    nxt_st.tout.active     = (nxt_st.seg == tv_timing_pkg::SEG_ACTIVE);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o  = st_ff.rdata;
  assign ctrl_o   = st_ff.ctrl;
  assign timing_o = st_ff.tout;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [9:0] age_ff;
  logic [9:0] exp_ff;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      age_ff <= 10'h000;
      exp_ff <= 10'h001;
    end else if (nxt_st.seg != st_ff.seg || st_ff.cnt == 10'h000) begin
      age_ff <= 10'h000;
      exp_ff <= nxt_st.cnt + 10'h001;
    end else begin
      age_ff <= age_ff + 10'h001;
    end
  end

  a_enable_readback: assert property (
    (req_i.rd && req_i.addr == tv_timing_pkg::STANDARDS_CONTROL_OFS)
      |=> rdata_o[7] == $past(standards_regs_enable_i))
    else $error("enable copy not read back");

  a_ctrl_gated: assert property (
    !standards_regs_enable_i |=> ctrl_o == '0)
    else $error("standard controls active while disabled");

  a_frame_wrap: assert property (
    (timing_o.line == 10'h000 && $past(timing_o.line) != 10'h000)
      |-> ($past(timing_o.line) == 10'h270 || $past(timing_o.line) == 10'h20C))
    else $error("frame wrapped at wrong line");

  a_pal_toggle: assert property (
    ($changed(timing_o.line) && $past(ctrl_o.pal)) |-> $changed(timing_o.phase_alt))
    else $error("phase did not alternate");

  a_pedestal_gain: assert property (
    standards_regs_enable_i |=> (ctrl_o.pedestal == $past(st_ff.regs[4'h0][4]) &&
      ctrl_o.luma_gain == $past(st_ff.regs[4'h0][3:2]) &&
      ctrl_o.chroma_gain == $past(st_ff.regs[4'h0][1:0])))
    else $error("control field mismatch");

  a_segment_length: assert property (
    (st_ff.cnt == 10'h000) |-> age_ff + 10'h001 == exp_ff)
    else $error("segment length differs from programmed count");

  a_eq_high_offset: assert property (
    (st_ff.seg == tv_timing_pkg::SEG_EQ_LOW && nxt_st.seg == tv_timing_pkg::SEG_EQ_HIGH)
      |=> st_ff.cnt + 10'h001 == $past(pulse_base) + {2'b00, $past(st_ff.regs[4'hC])})
    else $error("equalization high length wrong");

  a_vs_low_offset: assert property (
    (nxt_st.seg == tv_timing_pkg::SEG_VS_LOW && st_ff.seg != tv_timing_pkg::SEG_VS_LOW)
      |=> st_ff.cnt + 10'h001 == $past(pulse_base) + {2'b00, $past(st_ff.regs[4'hD])})
    else $error("vertical sync low length wrong");

  a_bar_step: assert property (
    (timing_o.active && $past(timing_o.active) && timing_o.bar_index != $past(timing_o.bar_index))
      |-> ($past(st_ff.bar_cnt) + 8'h01 >= $past(st_ff.regs[4'hF], 2) || 1'b0) ||
          ($past(st_ff.bar_cnt) + 8'h01 >= $past(st_ff.regs[4'hF])))
    else $error("bar stepped early");

  a_sync_order: assert property (
    (st_ff.seg == tv_timing_pkg::SEG_SYNC && st_ff.cnt == 10'h000)
      |=> st_ff.seg == tv_timing_pkg::SEG_BREEZE)
    else $error("breezeway did not follow sync");

  c_frame_wrap:  cover property (timing_o.line == 10'h000 && $past(timing_o.line) != 10'h000);
  c_pal_line:    cover property (ctrl_o.pal && $changed(timing_o.phase_alt));
  c_eq_high:     cover property (st_ff.seg == tv_timing_pkg::SEG_EQ_HIGH);
  c_last_bar:    cover property (timing_o.bar_index == tv_timing_pkg::LAST_BAR);

endmodule : tv_standard_line_timing_regs
`default_nettype wire

// ===== tb/host_model.sv
// Purpose: host model driving the timing register port and the outer enables
// Assumes: requests launched at falling edges, one cycle each
// Notes:   released address lines show the inverted last value; released data lines do so after writes only
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic                  ref_clk_i,
  input  wire logic [7:0]            rdata_i,
  output var  tv_timing_pkg::reg_req_t req_o,
  output var  logic                  enable_o,
  output var  logic                  offset_sel_o
);
  initial begin
    req_o        = '0;
    enable_o     = 1'b0;
    offset_sel_o = 1'b1;
  end

  task automatic set_enable(input logic en, input logic ofs);
    @(negedge ref_clk_i);
    enable_o     = en;
    offset_sel_o = ofs;
  endtask : set_enable

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge ref_clk_i);
    req_o = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(negedge ref_clk_i);
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge ref_clk_i);
    req_o = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: ~req_o.wdata};
    @(negedge ref_clk_i);
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: req_o.wdata};
    @(negedge ref_clk_i);
    data = rdata_i;
  endtask : read_reg
endmodule : host_model
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: self-checking bench for the tv standard line timing registers
// Assumes: host model launches every request at a falling edge
// Notes:   segment widths are counted on the registered timing outputs
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                       ref_clk_i;
  logic                       rst_n_i;
  tv_timing_pkg::reg_req_t    req;
  logic                       en;
  logic                       ofs;
  logic [7:0]                 rdata;
  tv_timing_pkg::std_ctrl_t   ctrl;
  tv_timing_pkg::timing_out_t tim;
  int                         error_cnt;
  int                         tests_run;
  int                         w;
  logic [7:0]                 rd_val;
  logic [7:0]                 val;
  logic                       pa;
  logic [7:0]                 len_tab [15] = '{8'h03, 8'h02, 8'h04, 8'h02, 8'h01, 8'h05,
    8'h07, 8'h09, 8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h02};

  host_model host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .req_o(req), .enable_o(en),
                   .offset_sel_o(ofs));
  tv_standard_line_timing_regs DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req),
    .standards_regs_enable_i(en), .long_pulse_offset_select_i(ofs), .rdata_o(rdata),
    .ctrl_o(ctrl), .timing_o(tim));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // ------------------------------------------------------------
  // checks and waits
  // ------------------------------------------------------------
  task automatic end_of_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_val(input string name, input logic [9:0] exp, input logic [9:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  task automatic chk_cnt(input string name, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      error_cnt++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_cnt

  function automatic logic sig(input int sel);
    case (sel)
      0: return tim.sync_n;
      1: return tim.burst_gate;
      default: return tim.active;
    endcase
  endfunction : sig

  // wait for a level, then count its cycles
  task automatic measure(input int sel, input logic lvl, output int cnt);
    int guard;
    guard = 0;
    cnt   = 0;
    while (sig(sel) !== lvl && guard < 2000) begin
      @(negedge ref_clk_i);
      guard++;
    end
    while (sig(sel) === lvl && cnt < 2000) begin
      @(negedge ref_clk_i);
      cnt++;
    end
    if (guard >= 2000 || cnt >= 2000) begin
      chk_cnt("segment wait", 0, 1);
      end_of_test();
    end
  endtask : measure

  task automatic wait_line(input logic [9:0] ln);
    int guard;
    guard = 0;
    while (tim.line !== ln && guard < 40000) begin
      @(negedge ref_clk_i);
      guard++;
    end
    if (guard >= 40000) begin
      chk_cnt("line wait", 0, 1);
      end_of_test();
    end
  endtask : wait_line

  task automatic next_line(input logic [9:0] exp);
    logic [9:0] cur;
    int         guard;
    cur   = tim.line;
    guard = 0;
    while (tim.line === cur && guard < 2000) begin
      @(negedge ref_clk_i);
      guard++;
    end
    chk_val("next line", exp, tim.line);
    if (guard >= 2000) begin
      chk_cnt("line wait", 0, 1);
      end_of_test();
    end
  endtask : next_line

  task automatic vbi(input logic [9:0] ln, input int lo, input int hi);
    wait_line(ln);
    measure(0, 1'b1, w);
    measure(0, 1'b0, w);
    chk_cnt("pulse low", lo, w);
    measure(0, 1'b1, w);
    chk_cnt("pulse high", hi, w);
  endtask : vbi

  task automatic seq(input logic [9:0] ln, input int first, input int gap, input int act);
    wait_line(ln);
    measure(2, 1'b1, w);
    chk_cnt("first active", first, w);
    measure(0, 1'b1, w);
    chk_cnt("front porch", 2, w);
    measure(0, 1'b0, w);
    chk_cnt("sync tip", 3, w);
    measure(1, 1'b0, w);
    chk_cnt("breezeway", 2, w);
    measure(1, 1'b1, w);
    chk_cnt("burst", 4, w);
    measure(2, 1'b0, w);
    chk_cnt("back porches", gap, w);
    measure(2, 1'b1, w);
    chk_cnt("active", act, w);
  endtask : seq

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst_n_i   = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    for (int a = 8'h0E; a <= 8'h1F; a++) begin
      host.read_reg(8'(a), rd_val);
      chk_val("reset value", {2'b00, tv_timing_pkg::REG_RESET}, {2'b00, rd_val});
    end
    for (int a = 8'h10; a <= 8'h1F; a++) host.write_reg(8'(a), 8'(a) ^ 8'h5A);
    for (int a = 8'h10; a <= 8'h1F; a++) begin
      host.read_reg(8'(a), rd_val);
      val = (a == 8'h1F) ? tv_timing_pkg::UNMAPPED_READ : 8'(a) ^ 8'h5A;
      chk_val("readback", {2'b00, val}, {2'b00, rd_val});
    end
    for (int i = 0; i < 15; i++) host.write_reg(8'h10 + 8'(i), len_tab[i]);
    host.write_reg(8'h0F, 8'hFF);
    host.read_reg(8'h0F, rd_val);
    chk_val("control read", 10'h07F, {2'b00, rd_val});
    chk_val("control gated", 10'h000, {3'h0, ctrl});
    host.set_enable(1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      val = {1'b0, i[0], i[1], ~i[0], i[1:0], ~i[1:0]};
      host.write_reg(8'h0F, val);
      repeat (2) @(negedge ref_clk_i);
      chk_val("controls", {3'h0, val[6:0]}, {3'h0, ctrl});
      host.read_reg(8'h0F, rd_val);
      chk_val("control read", {3'h1, val[6:0]}, {2'b00, rd_val});
    end
    host.set_enable(1'b0, 1'b1);
    repeat (2) @(negedge ref_clk_i);
    chk_val("control gated", 10'h000, {3'h0, ctrl});
    host.write_reg(8'h0F, 8'h20);
    vbi(10'h002, 3, 260);
    vbi(10'h003, 261, 6);
    host.set_enable(1'b1, 1'b1);
    vbi(10'h006, 3, 516);
    seq(10'h009, 7, 3, 5);
    host.write_reg(8'h18, 8'h50);
    seq(10'h00C, 261, 259, 261);
    host.write_reg(8'h18, 8'h01);
    wait_line(10'h014);
    pa = tim.phase_alt;
    wait_line(10'h015);
    chk_val("phase alt", {9'h000, !pa}, {9'h000, tim.phase_alt});
    // bar width 2: fifth active cycle shows bar 2
    wait_line(10'h016);
    measure(2, 1'b0, w);
    repeat (4) @(negedge ref_clk_i);
    chk_val("bar index", 10'h002, {7'h00, tim.bar_index});
    wait_line(10'h20C);
    measure(2, 1'b1, w);
    chk_cnt("end half active", 265, w);
    next_line(10'h000);
    val = {7'h00, tim.field};
    host.write_reg(8'h0F, 8'h40);
    wait_line(10'h01E);
    pa = tim.phase_alt;
    wait_line(10'h01F);
    chk_val("phase alt", {9'h000, pa}, {9'h000, tim.phase_alt});
    wait_line(10'h20C);
    next_line(10'h20D);
    wait_line(10'h270);
    next_line(10'h000);
    chk_val("field", {9'h000, ~val[0]}, {9'h000, tim.field});
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
